// >>> src/pgc_top.v
// Contract
// - Every generated frame is exactly the programmed length in bytes, reset 1500.
// - Idle gap between generated frames equals the 8-bit gap setting, reset 125.
// - 16-bit received byte counter; holds at maximum in single mode.
// - 32-bit received frame counter read as two halves; saturates in single mode.
// - 32-bit errored frame counter; saturates in single mode.
// - 8-bit errored bit counter; stops at 255 in single mode.
// - Writing status bit 0 snapshots all counters; counting continues.
// - Writing status bit 1 snapshots, then clears counters and overflow flags.
// - Frame counter overflow flag is sticky until the counters are cleared.
// - Byte counter overflow flag is sticky until the counters are cleared.
// - Read-only flag shows checker synchronisation to the received stream.
// - Done flag sets after all requested test frames are sent; zero meanwhile.
// - Busy flag is one while the generator operates, zero when idle.
// - Single mode stops at maximum; continuous mode pulses and restarts from zero.
// - The send request bit clears itself when done becomes set.
// - Upper errored frame half sits at the next index, same snapshot.
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pgc_consts.vh"

module pgc_top
(
    input  wire        i_clk,
    input  wire        i_reset,
    // Avalon-MM slave
    input  wire [13:0] i_avs_address,
    input  wire        i_avs_read,
    input  wire        i_avs_write,
    input  wire [31:0] i_avs_writedata,
    input  wire [3:0]  i_avs_byteenable,
    output reg  [31:0] o_avs_readdata,
    output wire        o_avs_waitrequest,
    output reg  [1:0]  o_avs_response,
    // Transmit datapath tap
    input  wire        i_tx_ready,
    output reg         o_tx_valid,
    output reg         o_tx_sof,
    output reg         o_tx_eof,
    // Receive checker tap
    input  wire        i_rx_byte_valid,
    input  wire        i_rx_frame_end,
    input  wire        i_rx_frame_err,
    input  wire        i_rx_bit_err,
    input  wire        i_rx_sync,
    // Counter wrap pulse and interrupt
    output reg         o_wrap_pulse,
    output wire        o_irq
);

    //==========================================================
    // Bus slave handshake
    //==========================================================
    reg         ack_ff;
    wire        req = i_avs_read | i_avs_write;
    wire        acc = req & ~ack_ff;
    wire [11:0] idx = i_avs_address[13:2];
    wire        lo_en = i_avs_byteenable[0];
    wire        hi_en = i_avs_byteenable[1];

    // One wait cycle; answer on the second edge
    assign o_avs_waitrequest = req & ~ack_ff;

    // Decodes whether an index is mapped
    function is_mapped;
        input [11:0] a;
        begin
            is_mapped = (a == `PGC_IDX_FRAME_LEN) || (a == `PGC_IDX_GAP) ||
                        (a == `PGC_IDX_BYTE_CNT) || (a == `PGC_IDX_FRAME_LO) ||
                        (a == `PGC_IDX_FRAME_HI) || (a == `PGC_IDX_STATUS) ||
                        (a == `PGC_IDX_ERRFRM_LO) || (a == `PGC_IDX_ERRFRM_HI) ||
                        (a == `PGC_IDX_CTRL) || (a == `PGC_IDX_IRQ_STAT) ||
                        (a == `PGC_IDX_IRQ_MASK);
        end
    endfunction

    wire wr = acc & i_avs_write & is_mapped(idx);
    wire rd = acc & i_avs_read & is_mapped(idx);
    wire wr_len    = wr & (idx == `PGC_IDX_FRAME_LEN);
    wire wr_gap    = wr & (idx == `PGC_IDX_GAP) & lo_en;
    wire wr_status = wr & (idx == `PGC_IDX_STATUS) & lo_en;
    wire wr_ctrl   = wr & (idx == `PGC_IDX_CTRL);
    wire wr_mask   = wr & (idx == `PGC_IDX_IRQ_MASK) & lo_en;
    wire rd_irq    = rd & (idx == `PGC_IDX_IRQ_STAT);
    wire snap      = wr_status & (i_avs_writedata[`PGC_ST_SNAP_BIT] |
                                  i_avs_writedata[`PGC_ST_CLEAR_BIT]);
    wire clr       = wr_status & i_avs_writedata[`PGC_ST_CLEAR_BIT];

    //==========================================================
    // Configuration registers
    //==========================================================
    reg [15:0] frame_len_ff;
    reg [7:0]  gap_ff;
    reg        gen_en_ff;
    reg        prbs_mode_ff;
    reg        cont_mode_ff;
    reg        send_ff;
    reg [3:0]  mask_ff;
    reg        done_ff;
    reg        gen_done_evt;

    // Settings written by software; send clears itself on done
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            frame_len_ff <= `PGC_RST_FRAME_LEN;
            gap_ff       <= `PGC_RST_GAP;
            gen_en_ff    <= 1'b0;
            prbs_mode_ff <= 1'b0;
            cont_mode_ff <= 1'b0;
            send_ff      <= 1'b0;
            mask_ff      <= 4'h0;
        end
        else
        begin
            if (wr_len)
            begin
                if (lo_en)
                    frame_len_ff[7:0] <= i_avs_writedata[7:0];
                if (hi_en)
                    frame_len_ff[15:8] <= i_avs_writedata[15:8];
            end
            if (wr_gap)
                gap_ff <= i_avs_writedata[7:0];
            if (wr_mask)
                mask_ff <= i_avs_writedata[3:0];
            if (wr_ctrl & lo_en)
            begin
                gen_en_ff    <= i_avs_writedata[`PGC_CT_GEN_EN_BIT];
                prbs_mode_ff <= i_avs_writedata[`PGC_CT_PRBS_BIT];
                cont_mode_ff <= i_avs_writedata[`PGC_CT_CONT_BIT];
            end
            if (gen_done_evt)
                send_ff <= 1'b0;
            else if (wr_ctrl & hi_en)
                send_ff <= i_avs_writedata[`PGC_CT_SEND_BIT];
        end
    end

    //==========================================================
    // Frame generator
    //==========================================================
    localparam [1:0] ST_IDLE  = 2'b00;
    localparam [1:0] ST_FRAME = 2'b01;
    localparam [1:0] ST_GAP   = 2'b10;

    reg  [1:0]  state_ff;
    reg  [1:0]  nxt_state;
    reg  [15:0] cnt_ff;
    reg  [15:0] nxt_cnt;
    reg  [15:0] sent_ff;
    reg  [15:0] nxt_sent;
    reg  [15:0] run_frames_ff;
    wire        prbs_run = gen_en_ff & prbs_mode_ff;
    wire        crc_run  = gen_en_ff & ~prbs_mode_ff & send_ff;
    wire        run      = prbs_run | crc_run;
    wire        start    = wr_ctrl & hi_en & i_avs_writedata[`PGC_CT_SEND_BIT];

    // Next state of the generator sequencer
    always @*
    begin
        nxt_state    = state_ff;
        nxt_cnt      = cnt_ff;
        nxt_sent     = sent_ff;
        gen_done_evt = 1'b0;
        case (state_ff)
            ST_IDLE:
            begin
                nxt_sent = 16'h0000;
                if (run && frame_len_ff != 16'h0000)
                begin
                    nxt_state = ST_FRAME;
                    nxt_cnt   = 16'h0000;
                end
            end
            ST_FRAME:
            begin
                if (i_tx_ready)
                begin
                    if (cnt_ff == frame_len_ff - 16'h0001)
                    begin
                        nxt_sent = sent_ff + 16'h0001;
                        nxt_cnt  = 16'h0000;
                        if (crc_run && nxt_sent >= run_frames_ff)
                        begin
                            nxt_state    = ST_IDLE;
                            gen_done_evt = 1'b1;
                        end
                        else if (!run)
                            nxt_state = ST_IDLE;
                        else
                            nxt_state = (gap_ff == 8'h00) ? ST_FRAME : ST_GAP;
                    end
                    else
                        nxt_cnt = cnt_ff + 16'h0001;
                end
            end
            ST_GAP:
            begin
                if (!run)
                    nxt_state = ST_IDLE;
                else if (cnt_ff == {8'h00, gap_ff} - 16'h0001)
                begin
                    nxt_state = ST_FRAME;
                    nxt_cnt   = 16'h0000;
                end
                else
                    nxt_cnt = cnt_ff + 16'h0001;
            end
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    // Sequencer registers, done flag and byte strobes
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            state_ff      <= ST_IDLE;
            cnt_ff        <= 16'h0000;
            sent_ff       <= 16'h0000;
            run_frames_ff <= `PGC_RST_RUN_FRAMES;
            done_ff       <= 1'b0;
            o_tx_valid    <= 1'b0;
            o_tx_sof      <= 1'b0;
            o_tx_eof      <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            sent_ff  <= nxt_sent;
            if (gen_done_evt)
                done_ff <= 1'b1;
            else if (start)
                done_ff <= 1'b0;
            o_tx_valid <= (nxt_state == ST_FRAME);
            o_tx_sof   <= (nxt_state == ST_FRAME) && (nxt_cnt == 16'h0000);
            o_tx_eof   <= (nxt_state == ST_FRAME) && (nxt_cnt == frame_len_ff - 16'h0001);
        end
    end

    //==========================================================
    // Checker counters
    //==========================================================
    reg [15:0] byte_cnt_ff;
    reg [31:0] frame_cnt_ff;
    reg [31:0] errfrm_cnt_ff;
    reg [7:0]  biterr_cnt_ff;
    reg        byte_ov_ff;
    reg        frame_ov_ff;
    reg [15:0] byte_snap_ff;
    reg [31:0] frame_snap_ff;
    reg [31:0] errfrm_snap_ff;
    reg [7:0]  biterr_snap_ff;

    // single mode halts all counting once any counter is full
    wire halted   = ~cont_mode_ff & ((&byte_cnt_ff) | (&frame_cnt_ff) |
                                     (&errfrm_cnt_ff) | (&biterr_cnt_ff));
    wire byte_inc = i_rx_byte_valid & ~halted;
    wire frm_inc  = i_rx_frame_end & ~halted;
    wire efr_inc  = i_rx_frame_end & i_rx_frame_err & ~halted;
    wire ber_inc  = i_rx_bit_err & ~halted;
    wire byte_wrap = byte_inc & (&byte_cnt_ff);
    wire frm_wrap  = frm_inc & (&frame_cnt_ff);
    wire efr_wrap  = efr_inc & (&errfrm_cnt_ff);
    wire ber_wrap  = ber_inc & (&biterr_cnt_ff);

    // Running counters, overflow flags and snapshot copies
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            byte_cnt_ff    <= 16'h0000;
            frame_cnt_ff   <= 32'h00000000;
            errfrm_cnt_ff  <= 32'h00000000;
            biterr_cnt_ff  <= 8'h00;
            byte_ov_ff     <= 1'b0;
            frame_ov_ff    <= 1'b0;
            byte_snap_ff   <= 16'h0000;
            frame_snap_ff  <= 32'h00000000;
            errfrm_snap_ff <= 32'h00000000;
            biterr_snap_ff <= 8'h00;
            o_wrap_pulse   <= 1'b0;
        end
        else
        begin
            if (snap)
            begin
                byte_snap_ff   <= byte_cnt_ff;
                frame_snap_ff  <= frame_cnt_ff;
                errfrm_snap_ff <= errfrm_cnt_ff;
                biterr_snap_ff <= biterr_cnt_ff;
            end
            o_wrap_pulse <= byte_wrap | frm_wrap | efr_wrap | ber_wrap;
            if (clr)
            begin
                byte_cnt_ff   <= 16'h0000;
                frame_cnt_ff  <= 32'h00000000;
                errfrm_cnt_ff <= 32'h00000000;
                biterr_cnt_ff <= 8'h00;
                byte_ov_ff    <= 1'b0;
                frame_ov_ff   <= 1'b0;
            end
            else
            begin
                if (byte_inc)
                    byte_cnt_ff <= byte_cnt_ff + 16'h0001;
                if (frm_inc)
                    frame_cnt_ff <= frame_cnt_ff + 32'h00000001;
                if (efr_inc)
                    errfrm_cnt_ff <= errfrm_cnt_ff + 32'h00000001;
                if (ber_inc)
                    biterr_cnt_ff <= biterr_cnt_ff + 8'h01;
                if (byte_inc && byte_cnt_ff == 16'hFFFE || byte_wrap)
                    byte_ov_ff <= 1'b1;
                if (frm_inc && frame_cnt_ff == 32'hFFFFFFFE || frm_wrap)
                    frame_ov_ff <= 1'b1;
            end
        end
    end

    //==========================================================
    // Interrupts
    //==========================================================
    reg  [3:0] irq_stat_ff;
    reg        sync_d_ff;
    wire [3:0] irq_evt = {sync_d_ff & ~i_rx_sync,
                          frm_inc & (frame_cnt_ff == 32'hFFFFFFFE) | frm_wrap,
                          byte_inc & (byte_cnt_ff == 16'hFFFE) | byte_wrap,
                          gen_done_evt};

    // Sticky events; a read clears, a new event wins over the clear
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            irq_stat_ff <= 4'h0;
            sync_d_ff   <= 1'b0;
        end
        else
        begin
            sync_d_ff   <= i_rx_sync;
            irq_stat_ff <= (rd_irq ? 4'h0 : irq_stat_ff) | irq_evt;
        end
    end

    assign o_irq = |(irq_stat_ff & mask_ff);

    //==========================================================
    // Read data and response
    //==========================================================
    reg [15:0] rdata;

    // Read multiplexer
    always @*
    begin
        case (idx)
            `PGC_IDX_FRAME_LEN: rdata = frame_len_ff;
            `PGC_IDX_GAP:       rdata = {8'h00, gap_ff};
            `PGC_IDX_BYTE_CNT:  rdata = byte_snap_ff;
            `PGC_IDX_FRAME_LO:  rdata = frame_snap_ff[15:0];
            `PGC_IDX_FRAME_HI:  rdata = frame_snap_ff[31:16];
            `PGC_IDX_STATUS:    rdata = {3'b000, done_ff, state_ff != ST_IDLE,
                                         frame_ov_ff, byte_ov_ff, i_rx_sync,
                                         biterr_snap_ff};
            `PGC_IDX_ERRFRM_LO: rdata = errfrm_snap_ff[15:0];
            `PGC_IDX_ERRFRM_HI: rdata = errfrm_snap_ff[31:16];
            `PGC_IDX_CTRL:      rdata = {3'b000, send_ff, 8'h00, cont_mode_ff,
                                         1'b0, prbs_mode_ff, gen_en_ff};
            `PGC_IDX_IRQ_STAT:  rdata = {12'h000, irq_stat_ff};
            `PGC_IDX_IRQ_MASK:  rdata = {12'h000, mask_ff};
            default:            rdata = 16'h0000;
        endcase
    end

    // Answer registers
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            ack_ff         <= 1'b0;
            o_avs_readdata <= 32'h00000000;
            o_avs_response <= 2'b00;
        end
        else
        begin
            ack_ff <= acc;
            if (acc)
            begin
                o_avs_readdata <= i_avs_read ? {16'h0000, rdata} : 32'h00000000;
                o_avs_response <= is_mapped(idx) ? 2'b00 : 2'b11;
            end
        end
    end

endmodule
`default_nettype wire

// >>> src/pgc_consts.vh
`ifndef PGC_CONSTS_VH
`define PGC_CONSTS_VH

// Register indices (byte address is four times the index)
`define PGC_IDX_FRAME_LEN      12'h61A
`define PGC_IDX_GAP            12'h61B
`define PGC_IDX_BYTE_CNT       12'h61C
`define PGC_IDX_FRAME_LO       12'h61D
`define PGC_IDX_FRAME_HI       12'h61E
`define PGC_IDX_STATUS         12'h620
`define PGC_IDX_ERRFRM_LO      12'h622
`define PGC_IDX_ERRFRM_HI      12'h623
`define PGC_IDX_CTRL           12'h630
`define PGC_IDX_IRQ_STAT       12'h631
`define PGC_IDX_IRQ_MASK       12'h632

// Reset values
`define PGC_RST_FRAME_LEN      16'h05DC
`define PGC_RST_GAP            8'h7D
`define PGC_RST_RUN_FRAMES     16'h0001

// Status register fields
`define PGC_ST_SNAP_BIT        0
`define PGC_ST_CLEAR_BIT       1
`define PGC_ST_SYNC_BIT        8
`define PGC_ST_BYTE_OV_BIT     9
`define PGC_ST_FRAME_OV_BIT    10
`define PGC_ST_BUSY_BIT        11
`define PGC_ST_DONE_BIT        12

// Control register fields
`define PGC_CT_GEN_EN_BIT      0
`define PGC_CT_PRBS_BIT        1
`define PGC_CT_CONT_BIT        3
`define PGC_CT_SEND_BIT        12

// Interrupt status fields
`define PGC_IRQ_DONE_BIT       0
`define PGC_IRQ_BYTE_OV_BIT    1
`define PGC_IRQ_FRAME_OV_BIT   2
`define PGC_IRQ_SYNC_LOSS_BIT  3

`endif

// >>> test/pgc_props.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bus handshake and generator stream checks
module pgc_props
(
    input wire logic        i_clk,
    input wire logic        i_reset,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic [1:0]  o_avs_response,
    input wire logic        i_tx_ready,
    input wire logic        o_tx_valid,
    input wire logic        o_tx_sof,
    input wire logic        o_tx_eof,
    input wire logic        o_wrap_pulse,
    input wire logic        o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    property p_wait_one;
        (i_avs_read | i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait state not one cycle");
    property p_first_wait;
        $rose(i_avs_read | i_avs_write) |-> o_avs_waitrequest;
    endproperty
    a_first_wait: assert property (p_first_wait) else $error("no wait state");
    property p_idle_wait;
        !(i_avs_read | i_avs_write) |-> !o_avs_waitrequest;
    endproperty
    a_idle_wait: assert property (p_idle_wait) else $error("waitrequest while idle");
    property p_err_zero;
        o_avs_response == 2'b11 |-> o_avs_readdata == 32'h0;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error read not zero");
    property p_upper_zero;
        o_avs_readdata[31:16] == 16'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read data set");
    property p_sof_valid;
        o_tx_sof || o_tx_eof |-> o_tx_valid;
    endproperty
    a_sof_valid: assert property (p_sof_valid) else $error("marker without valid");
    property p_eof_gap;
        o_tx_valid && o_tx_eof && i_tx_ready |=> !o_tx_valid;
    endproperty
    a_eof_gap: assert property (p_eof_gap) else $error("no idle after frame");
    property p_hold;
        o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_sof) && $stable(o_tx_eof);
    endproperty
    a_hold: assert property (p_hold) else $error("byte dropped in stall");
    c_write: cover property (i_avs_write && !o_avs_waitrequest);
    c_eof: cover property (o_tx_valid && o_tx_eof && i_tx_ready);
    c_irq: cover property ($rose(o_irq));
    c_wrap: cover property (o_wrap_pulse);
endmodule
`default_nettype wire

// >>> test/pgc_dp_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Datapath model: stalling sink and byte source
module pgc_dp_model
(
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_tx_valid,
    input  wire logic i_tx_sof,
    input  wire logic i_tx_eof,
    output logic      o_tx_ready,
    output logic      o_rx_byte_valid,
    output logic      o_rx_frame_end,
    output logic      o_rx_frame_err,
    output logic      o_rx_bit_err,
    output logic      o_rx_sync
);
    logic [1:0]  ph_ff;
    logic [15:0] cnt_ff;
    logic [15:0] len_ff;
    logic [15:0] idle_ff;
    logic [15:0] gap_ff;
    logic [15:0] frames_ff;
    wire  [15:0] nxt_cnt = i_tx_sof ? 16'h0001 : cnt_ff + 16'h0001;
    initial
    begin
        {o_rx_byte_valid, o_rx_frame_end, o_rx_frame_err, o_rx_bit_err, o_rx_sync} = 5'h00;
    end
    // Ready stalls one cycle in four; measures frame length and gap
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            {ph_ff, cnt_ff, len_ff, idle_ff, gap_ff, frames_ff} <= 82'h0;
            o_tx_ready <= 1'b0;
        end
        else
        begin
            ph_ff      <= ph_ff + 2'h1;
            o_tx_ready <= (ph_ff != 2'h3);
            idle_ff    <= (i_tx_valid && o_tx_ready && i_tx_eof) ? 16'h0000 :
                          idle_ff + {15'h0000, !i_tx_valid};
            if (i_tx_valid && o_tx_ready)
            begin
                cnt_ff <= nxt_cnt;
                if (i_tx_sof)
                    gap_ff <= idle_ff;
                if (i_tx_eof)
                begin
                    len_ff    <= nxt_cnt;
                    frames_ff <= frames_ff + 16'h0001;
                end
            end
        end
    end
    // Sends bytes, optional frame end, and bit error pulses
    task send_rx(input int nb, input logic err, input int nbit);
        int i;
        begin
            for (i = 0; i < nb || i < nbit; i++)
            begin
                o_rx_byte_valid <= (i < nb);
                o_rx_bit_err    <= (i < nbit);
                o_rx_frame_end  <= (i == nb - 1);
                o_rx_frame_err  <= err && (i == nb - 1);
                @(posedge i_clk);
            end
            {o_rx_byte_valid, o_rx_frame_end, o_rx_frame_err, o_rx_bit_err} <= 4'h0;
            @(posedge i_clk);
        end
    endtask
    task set_sync(input logic v);
        o_rx_sync <= v;
        @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

// >>> test/pgc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pgc_consts.vh"
// ==========================================
// Register level bench for the test frame block
module pgc_top_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [13:0] av_addr = 14'h0;
    logic        av_rd = 1'b0;
    logic        av_wr = 1'b0;
    logic [31:0] av_wd = 32'h0;
    wire  [31:0] rdata;
    wire         wreq;
    wire  [1:0]  resp;
    wire         tx_ready, tx_valid, tx_sof, tx_eof;
    wire         rx_bv, rx_fe, rx_ferr, rx_be, rx_sync;
    wire         wrap;
    wire         irq;
    int          err_count = 0;
    int          checks_done = 0;
    int          wraps = 0;
    logic [1:0]  last_resp;
    logic [15:0] v;
    pgc_top u_pgc_top (.i_clk(clk), .i_reset(rst), .i_avs_address(av_addr),
        .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wd),
        .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .o_avs_response(resp), .i_tx_ready(tx_ready), .o_tx_valid(tx_valid),
        .o_tx_sof(tx_sof), .o_tx_eof(tx_eof), .i_rx_byte_valid(rx_bv),
        .i_rx_frame_end(rx_fe), .i_rx_frame_err(rx_ferr), .i_rx_bit_err(rx_be),
        .i_rx_sync(rx_sync), .o_wrap_pulse(wrap), .o_irq(irq));
    pgc_dp_model u_pgc_dp_model (.i_clk(clk), .i_reset(rst), .i_tx_valid(tx_valid),
        .i_tx_sof(tx_sof), .i_tx_eof(tx_eof), .o_tx_ready(tx_ready),
        .o_rx_byte_valid(rx_bv), .o_rx_frame_end(rx_fe), .o_rx_frame_err(rx_ferr),
        .o_rx_bit_err(rx_be), .o_rx_sync(rx_sync));
    // Clock and wrap pulse counting
    initial forever #5 clk = ~clk;
    always @(posedge clk) if (wrap === 1'b1) wraps <= wraps + 1;
    task chk(input [31:0] s, input [31:0] e, input string nm);
        checks_done++;
        if (s !== e)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Waits for the answer edge
    task bus_go(output [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        while (wreq !== 1'b0 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 20) err_count++;
        d = rdata[15:0];
        last_resp = resp;
    endtask
    task wr(input [11:0] a, input [15:0] d);
        av_addr <= {a, 2'b00};
        av_wd <= {16'h0000, d};
        av_wr <= 1'b1;
        bus_go(v);
        av_wr <= 1'b0;
        @(posedge clk);
    endtask
    task rd(input [11:0] a, output [15:0] d);
        av_addr <= {a, 2'b00};
        av_rd <= 1'b1;
        bus_go(d);
        av_rd <= 1'b0;
        @(posedge clk);
    endtask
    task rchk(input [11:0] a, input [15:0] e, input [15:0] m, input string nm);
        rd(a, v);
        chk(v & m, e, nm);
    endtask
    task wait_done;
        int n;
        for (n = 0; n < 60 && v[`PGC_ST_DONE_BIT] !== 1'b1; n++) rd(`PGC_IDX_STATUS, v);
    endtask
    task t_regs;
        rchk(`PGC_IDX_FRAME_LEN, 16'h05DC, 16'hFFFF, "len reset");
        rchk(`PGC_IDX_GAP, 16'h007D, 16'hFFFF, "gap reset");
        rchk(`PGC_IDX_STATUS, 16'h0000, 16'hFFFF, "status reset");
        rchk(12'h700, 16'h0000, 16'hFFFF, "unmapped data");
        chk(last_resp, 2'b11, "unmapped resp");
        wr(`PGC_IDX_GAP, 16'hFF03);
        rchk(`PGC_IDX_GAP, 16'h0003, 16'hFFFF, "gap field");
        wr(`PGC_IDX_FRAME_LEN, 16'h0005);
    endtask
    task t_prbs;
        int n;
        wr(`PGC_IDX_CTRL, 16'h0003);
        for (n = 0; n < 200 && u_pgc_dp_model.frames_ff < 3; n++) @(posedge clk);
        chk(u_pgc_dp_model.len_ff, 16'h0005, "frame length");
        chk(u_pgc_dp_model.gap_ff, 16'h0003, "frame gap");
        rchk(`PGC_IDX_STATUS, 16'h0800, 16'h0800, "busy run");
        wr(`PGC_IDX_CTRL, 16'h0000);
        repeat (20) @(posedge clk);
        rchk(`PGC_IDX_STATUS, 16'h0000, 16'h0800, "busy idle");
    endtask
    task t_send;
        logic [15:0] f0;
        f0 = u_pgc_dp_model.frames_ff;
        wr(`PGC_IDX_IRQ_MASK, 16'h0000);
        rd(`PGC_IDX_IRQ_STAT, v);
        wr(`PGC_IDX_CTRL, 16'h1001);
        rchk(`PGC_IDX_STATUS, 16'h0000, 16'h1000, "done busy");
        wait_done;
        chk(u_pgc_dp_model.frames_ff, f0 + 16'h0001, "one frame");
        rchk(`PGC_IDX_CTRL, 16'h0000, 16'h1000, "send cleared");
        chk(irq, 1'b0, "irq masked");
        wr(`PGC_IDX_IRQ_MASK, 16'h0001);
        chk(irq, 1'b1, "irq raised");
        rchk(`PGC_IDX_IRQ_STAT, 16'h0001, 16'h0001, "irq status");
        chk(irq, 1'b0, "irq cleared");
        wr(`PGC_IDX_CTRL, 16'h1001);
        rchk(`PGC_IDX_STATUS, 16'h0000, 16'h1000, "done restart");
        wait_done;
        wr(`PGC_IDX_CTRL, 16'h0000);
    endtask
    task t_counts;
        wr(`PGC_IDX_STATUS, 16'h0002);
        u_pgc_dp_model.send_rx(4, 1'b0, 0);
        u_pgc_dp_model.send_rx(4, 1'b1, 3);
        wr(`PGC_IDX_STATUS, 16'h0001);
        rchk(`PGC_IDX_BYTE_CNT, 16'h0008, 16'hFFFF, "bytes");
        rchk(`PGC_IDX_FRAME_LO, 16'h0002, 16'hFFFF, "frames lo");
        rchk(`PGC_IDX_FRAME_HI, 16'h0000, 16'hFFFF, "frames hi");
        rchk(`PGC_IDX_ERRFRM_LO, 16'h0001, 16'hFFFF, "err frames lo");
        rchk(`PGC_IDX_ERRFRM_HI, 16'h0000, 16'hFFFF, "err frames hi");
        rchk(`PGC_IDX_STATUS, 16'h0003, 16'h00FF, "bit errors");
        u_pgc_dp_model.send_rx(2, 1'b0, 0);
        rchk(`PGC_IDX_BYTE_CNT, 16'h0008, 16'hFFFF, "bytes locked");
        wr(`PGC_IDX_STATUS, 16'h0002);
        rchk(`PGC_IDX_BYTE_CNT, 16'h000A, 16'hFFFF, "bytes kept");
        wr(`PGC_IDX_STATUS, 16'h0001);
        rchk(`PGC_IDX_BYTE_CNT, 16'h0000, 16'hFFFF, "bytes cleared");
        u_pgc_dp_model.set_sync(1'b1);
        rchk(`PGC_IDX_STATUS, 16'h0100, 16'h0100, "sync on");
        u_pgc_dp_model.set_sync(1'b0);
        rchk(`PGC_IDX_STATUS, 16'h0000, 16'h0100, "sync off");
    endtask
    task t_limits;
        u_pgc_dp_model.send_rx(0, 1'b0, 300);
        u_pgc_dp_model.send_rx(3, 1'b0, 0);
        wr(`PGC_IDX_STATUS, 16'h0001);
        rchk(`PGC_IDX_STATUS, 16'h00FF, 16'h00FF, "bit err stop");
        rchk(`PGC_IDX_BYTE_CNT, 16'h0000, 16'hFFFF, "single halt");
        wr(`PGC_IDX_STATUS, 16'h0002);
        wr(`PGC_IDX_CTRL, 16'h0008);
        u_pgc_dp_model.send_rx(65537, 1'b0, 0);
        wr(`PGC_IDX_STATUS, 16'h0001);
        rchk(`PGC_IDX_BYTE_CNT, 16'h0001, 16'hFFFF, "byte wrap");
        rchk(`PGC_IDX_STATUS, 16'h0200, 16'h0200, "byte ov set");
        chk(wraps, 1, "wrap pulses");
        wr(`PGC_IDX_STATUS, 16'h0002);
        rchk(`PGC_IDX_STATUS, 16'h0000, 16'h0600, "ov cleared");
    endtask
    // Watchdog that fails a run still going after 900000 ns
    initial
    begin
        #900000;
        err_count++;
        test_done;
    end
    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs;
        t_prbs;
        t_send;
        t_counts;
        t_limits;
        test_done;
    end
endmodule
bind pgc_top pgc_props u_pgc_props (.i_clk(i_clk), .i_reset(i_reset),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_avs_response(o_avs_response), .i_tx_ready(i_tx_ready), .o_tx_valid(o_tx_valid),
    .o_tx_sof(o_tx_sof), .o_tx_eof(o_tx_eof), .o_wrap_pulse(o_wrap_pulse), .o_irq(o_irq));
`default_nettype wire
